//--- sdc_pkg.sv
// Constants, register map and field layouts of the sigma-delta converter control block
// Behaviour
// - Converter runs only while the enable bit is 1; setting it leaves shutdown.
// - Disabled converter sits in shutdown with every clock feeding it gated off.
// - Shutdown keeps all settings but forces the system mode field to idle 000b.
// - Reference select 1 picks the external reference, 0 the internal one.
// - Input path is single-ended against analog ground or differential between two inputs.
// - Gain field picks one of eight amplifier gains, 1 through 128.
// - Positive and negative inputs each choose low buffer, high buffer or bypass.
// - A divisor register sets the modulator clock rate.
// - Modulator takes one input sample every 128 modulator clocks.
// - Decimation ratio is one plus an 11-bit split field; one word per ratio samples.
// - Output word rate is sample rate divided by decimation ratio.
// - Two separately programmable decimation filters, throughput up to 1 kHz; here the fast filter window is fixed at ratio/8.
// - An 8-bit offset correction setting cancels large input offsets.
// - Result is 24 bits on high-resolution parts, 16 bits on reduced ones.
// - Writing a calibration encoding starts calibration; at its end mode returns idle.
// - Busy reads 1 during calibration; at end busy clears, complete sets, interrupt raised.
package sdc_pkg;
   // ------------------------------------------------------------
   // Bus geometry and register byte addresses
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_BUFFER = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_CLKDIV = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_DECIMATION_FIELD_HI = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_DECIMATION_FIELD_LO = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_OFFSET = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_FAST = 8'h28;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int MODE_EN_BIT = 7;
   localparam int CFG_REF_BIT = 0;
   localparam int CFG_DIFF_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_CALC_BIT = 1;
   localparam int STAT_WORD_BIT = 2;
   // ------------------------------------------------------------
   // System mode encodings
   // ------------------------------------------------------------
   localparam logic [2:0] SM_IDLE = 3'h0;
   localparam logic [2:0] SM_SINGLE = 3'h1;
   localparam logic [2:0] SM_CONT = 3'h2;
   localparam logic [2:0] SM_CAL_IOFS = 3'h4;
   localparam logic [2:0] SM_CAL_IGAIN = 3'h5;
   localparam logic [2:0] SM_CAL_SOFS = 3'h6;
   localparam logic [2:0] SM_CAL_SGAIN = 3'h7;
   localparam int SM_CAL_BIT = 2;
   // Buffer select encodings, per input
   localparam logic [1:0] BUF_BYPASS = 2'h0;
   localparam logic [1:0] BUF_LOW = 2'h1;
   localparam logic [1:0] BUF_HIGH = 2'h2;
   // ------------------------------------------------------------
   // Timing and arithmetic constants
   // ------------------------------------------------------------
   localparam longint REF_CLK_HZ = 200000000;
   localparam longint MOD_TARGET_HZ = 2457600;
   localparam logic [7:0] CLKDIV_RST = 8'((REF_CLK_HZ / MOD_TARGET_HZ) - 1);
   localparam int SAMP_DIV = 128;
   localparam logic [6:0] SAMP_LAST = 7'(SAMP_DIV - 1);
   localparam int DECIMATION_FIELD_W = 11;
   localparam logic [DECIMATION_FIELD_W-1:0] DECIMATION_FIELD_RST = 11'h7ff;
   localparam int FAST_SHIFT = 3;
   localparam int RES_W_HI = 24;
   localparam int RES_W_LO = 16;
   localparam int CNT_W = 12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- sdc_clkgen.sv
// Modulator clock divider and sample strobe generator
`timescale 1ns/1ps
`default_nettype none
module sdc_clkgen (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Control
   input wire logic run,
   input wire logic [7:0] clk_div,
   // Strobes
   output logic mod_tick,
   output logic samp_tick
);
   import sdc_pkg::*;

   logic [7:0] div_cnt_q, div_cnt_d, div_lat_q, div_lat_d;
   logic [6:0] samp_cnt_q, samp_cnt_d;
   logic mod_tick_q, mod_tick_d, samp_tick_q, samp_tick_d;

   // Divider: the divisor is latched only at a period wrap or while stopped, so a rewrite never yields a runt period
   always_comb begin
      div_cnt_d = div_cnt_q;
      div_lat_d = div_lat_q;
      samp_cnt_d = samp_cnt_q;
      mod_tick_d = 1'b0;
      samp_tick_d = 1'b0;
      if (!run) begin
         div_cnt_d = 8'h00;
         div_lat_d = clk_div;
         samp_cnt_d = 7'h00;
      end else if (div_cnt_q == div_lat_q) begin
         div_cnt_d = 8'h00;
         div_lat_d = clk_div;
         mod_tick_d = 1'b1;
         samp_cnt_d = 7'(samp_cnt_q + 7'h01);
         samp_tick_d = (samp_cnt_q == SAMP_LAST);
      end else begin
         div_cnt_d = 8'(div_cnt_q + 8'h01);
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt_q <= 8'h00;
         div_lat_q <= CLKDIV_RST;
         samp_cnt_q <= 7'h00;
         mod_tick_q <= 1'b0;
         samp_tick_q <= 1'b0;
      end else begin
         div_cnt_q <= div_cnt_d;
         div_lat_q <= div_lat_d;
         samp_cnt_q <= samp_cnt_d;
         mod_tick_q <= mod_tick_d;
         samp_tick_q <= samp_tick_d;
      end
   end

   assign mod_tick = mod_tick_q;
   assign samp_tick = samp_tick_q;

   // Helper: cycles since last modulator tick; primed to minus one while stopped so the first period counts right
   logic [8:0] gap_q;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gap_q <= 9'h000;
      end else begin
         gap_q <= !run ? '1 : (mod_tick_q ? 9'h000 : 9'(gap_q + 9'h001));
      end
   end

   tick_period_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (mod_tick_q && run && $past(run) && $stable(div_lat_q)) |-> (gap_q == 9'({1'b0, div_lat_q})))
      else $error("modulator tick period differs from divisor plus one");
   no_tick_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !run |=> !mod_tick_q && !samp_tick_q)
      else $error("strobe while converter disabled");
   samp_on_mod_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      samp_tick_q |-> mod_tick_q && (samp_cnt_q == 7'h00))
      else $error("sample strobe not on 128th modulator tick");
endmodule
`default_nettype wire

//--- sdc_top.sv
// Sigma-delta converter control: register file, mode sequencing and two decimation filters
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sdc_top #(
   parameter bit HI_RES = 1'b1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // AXI4-Lite write address, data and response
   input wire logic [sdc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [sdc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Modulator bitstream from the analog front end
   input wire logic mod_bit,
   // Analog front end controls
   output logic conv_clk_en,
   output logic mod_clk_tick,
   output logic ref_external,
   output logic input_differential,
   output logic [2:0] amplifier_gain_field,
   output logic [1:0] positive_input_buf,
   output logic [1:0] negative_input_buf,
   output logic [7:0] offset_dac,
   output logic [2:0] system_mode_field,
   // Events
   output logic word_strobe,
   output logic fast_strobe,
   output logic cal_done_irq
);
   import sdc_pkg::*;

   localparam int RES_W = HI_RES ? RES_W_HI : RES_W_LO;

   // ------------------------------------------------------------
   // Register file state
   // ------------------------------------------------------------
   logic en_q, en_d, ref_q, ref_d, diff_q, diff_d;
   logic [2:0] sm_q, sm_d, gain_q, gain_d;
   logic [1:0] pbuf_q, pbuf_d, nbuf_q, nbuf_d;
   logic [7:0] div_q, div_d, ofs_q, ofs_d;
   logic [DECIMATION_FIELD_W-1:0] decimation_field_q, decimation_field_d;
   logic calc_q, calc_d, wrdy_q, wrdy_d;
   logic [RES_W-1:0] res_q, res_d, fres_q, fres_d;

   // ------------------------------------------------------------
   // Bus slave state
   // ------------------------------------------------------------
   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bv_q, bv_d, rv_q, rv_d;
   logic [ADDR_W-1:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [3:0] ws_q, ws_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic wr_go, wr_hit;
   logic [31:0] rd_val;
   logic rd_hit;

   // Filter state
   logic [DECIMATION_FIELD_W-1:0] dcnt_q, dcnt_d, fcnt_q, fcnt_d;
   logic [CNT_W-1:0] acc_q, acc_d, facc_q, facc_d;
   logic ws_q_ev, ws_d_ev, fs_q_ev, fs_d_ev, irq_q, irq_d;
   logic mod_tick, samp_tick;
   logic [CNT_W-1:0] ratio, fast_len;
   logic conv_run, word_evt, fast_evt;

   // ------------------------------------------------------------
   // Clock divider
   // ------------------------------------------------------------
   sdc_clkgen u_clkgen (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .run(en_q),
      .clk_div(div_q),
      .mod_tick(mod_tick),
      .samp_tick(samp_tick)
   );

   // Address and data are latched independently; the write fires once both are held
   assign s_axi_awready = !aw_hold_q && !bv_q;
   assign s_axi_wready = !w_hold_q && !bv_q;
   assign s_axi_arready = !rv_q;
   assign wr_go = aw_hold_q && w_hold_q && !bv_q;

   always_comb begin
      aw_hold_d = aw_hold_q;
      w_hold_d = w_hold_q;
      awa_d = awa_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_d = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb;
      end
      if (wr_go) begin
         aw_hold_d = 1'b0;
         w_hold_d = 1'b0;
         bv_d = 1'b1;
         br_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rd_d = rd_val;
         rr_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awa_q <= '0;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         bv_q <= 1'b0;
         br_q <= RESP_OKAY;
         rv_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         rr_q <= RESP_OKAY;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
      end
   end

   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;

   // Read mux; reserved bits read as zero
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         OFS_MODE: rd_val = 32'({en_q, 4'h0, sm_q});
         OFS_CONFIG: rd_val = 32'({diff_q, ref_q});
         OFS_CONTROL: rd_val = 32'(gain_q);
         OFS_BUFFER: rd_val = 32'({nbuf_q, pbuf_q});
         OFS_CLKDIV: rd_val = 32'(div_q);
         OFS_DECIMATION_FIELD_HI: rd_val = 32'(decimation_field_q[DECIMATION_FIELD_W-1:8]);
         OFS_DECIMATION_FIELD_LO: rd_val = 32'(decimation_field_q[7:0]);
         OFS_OFFSET: rd_val = 32'(ofs_q);
         OFS_STATUS: rd_val = 32'({wrdy_q, calc_q, sm_q[SM_CAL_BIT]});
         OFS_RESULT: rd_val = 32'(res_q);
         OFS_FAST: rd_val = 32'(fres_q);
         default: rd_hit = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // Register writes and mode sequencing
   // ------------------------------------------------------------
   always_comb begin
      wr_hit = 1'b1;
      case (awa_q)
         OFS_MODE, OFS_CONFIG, OFS_CONTROL, OFS_BUFFER, OFS_CLKDIV,
         OFS_DECIMATION_FIELD_HI, OFS_DECIMATION_FIELD_LO, OFS_OFFSET, OFS_STATUS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   assign word_evt = samp_tick && (dcnt_q == decimation_field_q) && (sm_q != SM_IDLE);
   assign fast_evt = samp_tick && (fcnt_q == 11'(fast_len - 12'h001)) && (sm_q != SM_IDLE);

   always_comb begin
      en_d = en_q;
      ref_d = ref_q;
      diff_d = diff_q;
      sm_d = sm_q;
      gain_d = gain_q;
      pbuf_d = pbuf_q;
      nbuf_d = nbuf_q;
      div_d = div_q;
      decimation_field_d = decimation_field_q;
      ofs_d = ofs_q;
      calc_d = calc_q;
      wrdy_d = wrdy_q;
      irq_d = 1'b0;
      if (wr_go && ws_q[0]) begin
         case (awa_q)
            OFS_MODE: begin
               en_d = wd_q[MODE_EN_BIT];
               sm_d = wd_q[2:0];
            end
            OFS_CONFIG: begin
               ref_d = wd_q[CFG_REF_BIT];
               diff_d = wd_q[CFG_DIFF_BIT];
            end
            OFS_CONTROL: gain_d = wd_q[2:0];
            OFS_BUFFER: begin
               pbuf_d = wd_q[1:0];
               nbuf_d = wd_q[3:2];
            end
            OFS_CLKDIV: div_d = wd_q[7:0];
            OFS_DECIMATION_FIELD_HI: decimation_field_d[DECIMATION_FIELD_W-1:8] = wd_q[2:0];
            OFS_DECIMATION_FIELD_LO: decimation_field_d[7:0] = wd_q[7:0];
            OFS_OFFSET: ofs_d = wd_q[7:0];
            OFS_STATUS: begin
               if (wd_q[STAT_CALC_BIT]) calc_d = 1'b0;
               if (wd_q[STAT_WORD_BIT]) wrdy_d = 1'b0;
            end
            default: ofs_d = ofs_q;
         endcase
      end
      // Completion events come after the clears so a simultaneous set wins
      if (word_evt) begin
         wrdy_d = 1'b1;
         if (sm_q[SM_CAL_BIT]) begin
            sm_d = SM_IDLE;
            calc_d = 1'b1;
            irq_d = 1'b1;
         end else if (sm_q == SM_SINGLE) begin
            sm_d = SM_IDLE;
         end
      end
      // Shutdown keeps every setting except the mode field
      if (!en_d) sm_d = SM_IDLE;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         en_q <= 1'b0;
         ref_q <= 1'b0;
         diff_q <= 1'b0;
         sm_q <= SM_IDLE;
         gain_q <= 3'h0;
         pbuf_q <= BUF_BYPASS;
         nbuf_q <= BUF_BYPASS;
         div_q <= CLKDIV_RST;
         decimation_field_q <= DECIMATION_FIELD_RST;
         ofs_q <= 8'h00;
         calc_q <= 1'b0;
         wrdy_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         en_q <= en_d;
         ref_q <= ref_d;
         diff_q <= diff_d;
         sm_q <= sm_d;
         gain_q <= gain_d;
         pbuf_q <= pbuf_d;
         nbuf_q <= nbuf_d;
         div_q <= div_d;
         decimation_field_q <= decimation_field_d;
         ofs_q <= ofs_d;
         calc_q <= calc_d;
         wrdy_q <= wrdy_d;
         irq_q <= irq_d;
      end
   end

   // ------------------------------------------------------------
   // Decimation filters: main over ratio samples, fast over ratio/8
   // ------------------------------------------------------------
   // Ratio below 8 would give a zero-length fast window, so it is floored at one sample
   assign ratio = CNT_W'({1'b0, decimation_field_q}) + 12'h001;
   assign fast_len = ((ratio >> FAST_SHIFT) == 12'h000) ? 12'h001 : (ratio >> FAST_SHIFT);
   assign conv_run = en_q && (sm_q != SM_IDLE);

   always_comb begin
      dcnt_d = dcnt_q;
      fcnt_d = fcnt_q;
      acc_d = acc_q;
      facc_d = facc_q;
      res_d = res_q;
      fres_d = fres_q;
      ws_d_ev = word_evt;
      fs_d_ev = fast_evt;
      if (!conv_run) begin
         dcnt_d = '0;
         fcnt_d = '0;
         acc_d = '0;
         facc_d = '0;
      end else if (samp_tick) begin
         if (word_evt) begin
            dcnt_d = '0;
            acc_d = '0;
            res_d = RES_W'(acc_q + CNT_W'(mod_bit));
         end else begin
            dcnt_d = 11'(dcnt_q + 11'h001);
            acc_d = 12'(acc_q + CNT_W'(mod_bit));
         end
         if (fast_evt) begin
            fcnt_d = '0;
            facc_d = '0;
            fres_d = RES_W'(facc_q + CNT_W'(mod_bit));
         end else begin
            fcnt_d = 11'(fcnt_q + 11'h001);
            facc_d = 12'(facc_q + CNT_W'(mod_bit));
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dcnt_q <= '0;
         fcnt_q <= '0;
         acc_q <= '0;
         facc_q <= '0;
         res_q <= '0;
         fres_q <= '0;
         ws_q_ev <= 1'b0;
         fs_q_ev <= 1'b0;
      end else begin
         dcnt_q <= dcnt_d;
         fcnt_q <= fcnt_d;
         acc_q <= acc_d;
         facc_q <= facc_d;
         res_q <= res_d;
         fres_q <= fres_d;
         ws_q_ev <= ws_d_ev;
         fs_q_ev <= fs_d_ev;
      end
   end

   // Front-end outputs
   assign conv_clk_en = en_q;
   assign mod_clk_tick = mod_tick;
   assign ref_external = ref_q;
   assign input_differential = diff_q;
   assign amplifier_gain_field = gain_q;
   assign positive_input_buf = pbuf_q;
   assign negative_input_buf = nbuf_q;
   assign offset_dac = ofs_q;
   assign system_mode_field = sm_q;
   assign word_strobe = ws_q_ev;
   assign fast_strobe = fs_q_ev;
   assign cal_done_irq = irq_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence cal_running_s;
      sm_q[SM_CAL_BIT] && en_q && word_evt;
   endsequence
   sequence cal_closed_s;
      (sm_q == SM_IDLE) && calc_q && irq_q && !sm_q[SM_CAL_BIT];
   endsequence

   cal_finish_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cal_running_s |=> cal_closed_s)
      else $error("calibration end did not idle, flag and interrupt");
   shutdown_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !en_q |-> (sm_q == SM_IDLE))
      else $error("mode field not idle in shutdown");
   settings_kept_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      $fell(en_q) |-> $stable(gain_q) && $stable(decimation_field_q) && $stable(div_q) && $stable(ofs_q))
      else $error("settings changed on entering shutdown");
   no_word_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !en_q |=> !word_strobe && !fast_strobe)
      else $error("output word while disabled");
   calc_set_wins_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (word_evt && sm_q[SM_CAL_BIT] && en_q) |=> calc_q)
      else $error("complete flag lost against clear");
   // Helper: samples since the main window opened, counted apart from the filter counter
   logic [DECIMATION_FIELD_W-1:0] nsamp_q;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         nsamp_q <= '0;
      end else if (!conv_run || word_strobe) begin
         nsamp_q <= '0;
      end else if (samp_tick) begin
         nsamp_q <= DECIMATION_FIELD_W'(nsamp_q + 11'h001);
      end
   end

   word_spacing_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (samp_tick && conv_run) |-> (word_evt == (nsamp_q == decimation_field_q)))
      else $error("word produced at wrong sample count");
   gain_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (wr_go && ws_q[0] && awa_q == OFS_CONTROL) |=> (amplifier_gain_field == $past(wd_q[2:0])))
      else $error("gain field not applied");
   ref_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (wr_go && ws_q[0] && awa_q == OFS_CONFIG) |=> (ref_external == $past(wd_q[CFG_REF_BIT])))
      else $error("reference select not applied");
   bresp_follow_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      wr_go |=> s_axi_bvalid)
      else $error("write response missing");
endmodule
`default_nettype wire

//--- sdc_front_model.sv
// Behavioural analog front end that feeds the modulator bitstream
`timescale 1ns/1ps
`default_nettype none
module sdc_front_model (
   // Clock and gating
   input wire logic ref_clk,
   input wire logic clk_en,
   input wire logic level,
   // Bitstream
   output logic mod_bit
);
   // A gated front end toggles so a stale bit is never taken for data
   initial mod_bit = 1'b0;
   always @(posedge ref_clk) begin
      mod_bit <= clk_en ? level : ~mod_bit;
   end
endmodule
`default_nettype wire

//--- tb_sdc_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_sdc_top;
   import sdc_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [1:0] rsp; logic [16:0] o;} sdc_row_t;
   logic ref_clk, sys_rst, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, mb, lvl;
   logic cen, mtk, o_ref, o_dif, wst, fst, irq;
   logic [7:0] awa, ara, o_ofs;
   logic [31:0] wd, rdat;
   logic [1:0] bresp, rresp, o_pb, o_nb;
   logic [2:0] o_gn, sm;
   logic [16:0] outs;
   int errors = 0;
   int total_checks = 0;
   int cyc = 0;
   // Register writes beside the control outputs they should give
   sdc_row_t rows[8] = '{'{OFS_CONFIG, 8'h01, RESP_OKAY, 17'h10000},
      '{OFS_CONFIG, 8'h02, RESP_OKAY, 17'h08000}, '{OFS_BUFFER, 8'h09, RESP_OKAY, 17'h08600},
      '{OFS_BUFFER, 8'h06, RESP_OKAY, 17'h08900}, '{OFS_BUFFER, 8'h00, RESP_OKAY, 17'h08000},
      '{OFS_OFFSET, 8'ha5, RESP_OKAY, 17'h080a5}, '{OFS_CONTROL, 8'h07, RESP_OKAY, 17'h0f0a5},
      '{8'h2c, 8'h5a, RESP_SLVERR, 17'h0f0a5}};
   assign outs = {o_ref, o_dif, o_gn, o_pb, o_nb, o_ofs};
   sdc_top sdc_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .mod_bit(mb), .conv_clk_en(cen), .mod_clk_tick(mtk), .ref_external(o_ref), .input_differential(o_dif),
      .amplifier_gain_field(o_gn), .positive_input_buf(o_pb), .negative_input_buf(o_nb), .offset_dac(o_ofs),
      .system_mode_field(sm), .word_strobe(wst), .fast_strobe(fst), .cal_done_irq(irq));
   sdc_front_model sdc_front_model_inst (.ref_clk(ref_clk), .clk_en(cen), .level(lvl), .mod_bit(mb));
   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Handshakes are sampled at the falling edge, where the values the rising edge sees are settled
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      @(posedge ref_clk);
      {awa, wd, awv, wv, br} <= {a, 24'h0, d, 3'b111};
      forever begin
         @(negedge ref_clk);
         {ta, tw, tb, r} = {awv && awr, wv && wrd, bv, bresp};
         @(posedge ref_clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tb) begin
            br <= 1'b0;
            return;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic ta, tk;
      @(posedge ref_clk);
      {ara, arv, rr} <= {a, 2'b11};
      forever begin
         @(negedge ref_clk);
         {ta, tk, v} = {arv && arr, rv, rdat};
         @(posedge ref_clk);
         if (ta) arv <= 1'b0;
         if (tk) begin
            rr <= 1'b0;
            return;
         end
      end
   endtask
   function automatic logic pick(input int s);
      return s == 0 ? mtk : s == 1 ? wst : s == 2 ? fst : irq;
   endfunction
   task automatic wait_on(input int s);
      do @(negedge ref_clk); while (pick(s) !== 1'b1);
   endtask
   // Cycles from one pulse to the next
   task automatic gap(input int s, output int n);
      n = 0;
      wait_on(s);
      do begin
         @(negedge ref_clk);
         n++;
      end while (pick(s) !== 1'b1);
   endtask
   // Hang guard, well above the longest expected run
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         report_and_stop();
      end
   end
   initial begin
      logic [31:0] v;
      logic [1:0] r;
      int n;
      {awa, ara, wd, awv, wv, br, arv, rr, lvl} = '0;
      sys_rst = 1'b1;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, r);
         chk("bresp", rows[i].rsp, r);
         rd(rows[i].a, v);
         chk("rresp", rows[i].rsp, rresp);
         chk("readback", rows[i].rsp == RESP_OKAY ? rows[i].d : 8'h00, v);
         chk("controls", rows[i].o, outs);
      end
      for (int g = 0; g < 8; g++) begin
         wr(OFS_CONTROL, 8'(g), r);
         chk("gain", g, o_gn);
      end
      $display("test registers done");
      // Short divisor and ratio keep the run brief; ratio 24 is legal for both filters
      lvl <= 1'b1;
      wr(OFS_CLKDIV, 8'h01, r);
      wr(OFS_DECIMATION_FIELD_HI, 8'h00, r);
      wr(OFS_DECIMATION_FIELD_LO, 8'd23, r);
      wr(OFS_MODE, 8'h84, r);
      chk("enable", 1, cen);
      rd(OFS_STATUS, v);
      chk("busy", 1, v[0]);
      gap(0, n);
      chk("mod period", 2, n);
      wait_on(3);
      rd(OFS_STATUS, v);
      chk("status", 3'b110, v[2:0]);
      chk("mode", SM_IDLE, sm);
      rd(OFS_RESULT, v);
      chk("result", 24, v);
      wr(OFS_STATUS, 8'h02, r);
      rd(OFS_STATUS, v);
      chk("complete", 0, v[1]);
      $display("test calibration done");
      wr(OFS_MODE, 8'h82, r);
      gap(1, n);
      chk("word period", 24 * SAMP_DIV * 2, n);
      gap(2, n);
      chk("fast period", 3 * SAMP_DIV * 2, n);
      rd(OFS_FAST, v);
      chk("fast result", 3, v);
      wr(OFS_MODE, 8'h81, r);
      wait_on(1);
      chk("single idle", SM_IDLE, sm);
      $display("test continuous done");
      wr(OFS_MODE, 8'h02, r);
      chk("mode", SM_IDLE, sm);
      chk("controls", 17'h0f0a5, outs);
      n = 0;
      repeat (300) begin
         @(negedge ref_clk);
         if (mtk !== 1'b0 || cen !== 1'b0) n++;
      end
      chk("gated ticks", 0, n);
      rd(OFS_DECIMATION_FIELD_LO, v);
      chk("ratio kept", 23, v);
      $display("test shutdown done");
      sys_rst <= 1'b1;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      chk("controls", 0, outs);
      rd(OFS_CLKDIV, v);
      chk("divisor", CLKDIV_RST, v);
      rd(OFS_DECIMATION_FIELD_LO, v);
      chk("ratio low", 8'hff, v);
      $display("test reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
